// >>> rtl/hpr_defs.svh
// Constants for the hub port power and role control block
`ifndef HPR_DEFS_SVH
`define HPR_DEFS_SVH
`define HPR_NUM_PORTS    2
`define HPR_NUM_ATTACH   4
`define HPR_SYNC_STAGES  2
`define HPR_ROLE_DEFAULT 1'h0
`define HPR_ROLE_SWAPPED 1'h1
`define HPR_UP_PORT_DEF  2'h0
`define HPR_UP_PORT_SWP  2'h1
`define HPR_NUM_PINS     3
`define HPR_PIN_P1       0
`define HPR_PIN_P2       1
`define HPR_PIN_GANG     2
`define HPR_PIN_IDLE     3'h7
`define HPR_ATTACH_RESET 4'h0
`define HPR_PORTS_RESET  2'h0
`define HPR_ROLES_RESET  2'h2
`endif

// >>> rtl/hpr_pkg.sv
// Types for the hub port power and role control block
package hpr_pkg;
   // Drive side of one open-drain pin
   typedef struct packed {
      logic out;
      logic oe;
   } hpr_od_drive_t;
   // Role of each of ports 0 and 1
   typedef struct packed {
      logic port0_upstream;
      logic port1_upstream;
   } hpr_roles_t;
endpackage

// >>> rtl/hpr_port_power_role.sv
// Port power control, overcurrent sense, role swap and PHY gating
`timescale 1ns/1ps
`default_nettype none
`include "hpr_defs.svh"
module hpr_port_power_role (
   // Clock and reset
   input  wire  logic                        clk_sys,
   input  wire  logic                        rst,
   // Configuration and host control
   input  wire  logic                        ganged_mode,
   input  wire  logic [`HPR_NUM_PORTS-1:0]   port_cfg_enable,
   input  wire  logic [`HPR_NUM_PORTS-1:0]   port_host_enable,
   // Per-port open-drain power pins
   input  wire  logic                        port1_power_ctl_pin_in,
   output logic                              port1_power_ctl_pin_out,
   output logic                              port1_power_ctl_pin_oe,
   input  wire  logic                        port2_power_ctl_pin_in,
   output logic                              port2_power_ctl_pin_out,
   output logic                              port2_power_ctl_pin_oe,
   // Ganged open-drain power pin
   input  wire  logic                        ganged_power_pin_in,
   output logic                              ganged_power_pin_out,
   output logic                              ganged_power_pin_oe,
   // Port status
   output logic [`HPR_NUM_PORTS-1:0]         port_powered,
   output logic [`HPR_NUM_PORTS-1:0]         port_overcurrent,
   // Role swap
   input  wire  logic                        role_swap_cmd,
   output logic                              role_state_ind,
   output hpr_pkg::hpr_roles_t               port_roles,
   // Attach and PHY gating
   input  wire  logic [`HPR_NUM_ATTACH-1:0]  attach_in,
   output logic [`HPR_NUM_ATTACH-1:0]        ss_phy_enable
);
   // Pin vectors hold port 1, port 2 and the ganged pin, low bit first.
   // Keeping all three pins in one vector lets sync and masking share logic.
   // First synchroniser stages feed only the second stages.

   // Pick the pin that reports overcurrent for one port
   function automatic logic port_fault(
      input logic gang,
      input logic own_fault,
      input logic gang_fault
   );
      port_fault = gang ? gang_fault : own_fault;
   endfunction

   // Drive side of one open-drain pin; out stays low so oe alone decides
   function automatic hpr_pkg::hpr_od_drive_t od_drive(
      input logic drive_low
   );
      hpr_pkg::hpr_od_drive_t d;
      d.out = 1'h0;
      d.oe  = drive_low;
      return d;
   endfunction

   // Synchroniser stages for the asynchronous pins
   logic [`HPR_NUM_ATTACH-1:0] attach_s1;
   logic [`HPR_NUM_ATTACH-1:0] attach_s2;
   logic                       swap_s1;
   logic                       swap_s2;
   logic [`HPR_NUM_PINS-1:0]   pin_s1;
   logic [`HPR_NUM_PINS-1:0]   pin_s2;

   // Release history of each pin
   logic [`HPR_NUM_PINS-1:0]   released_q1;
   logic [`HPR_NUM_PINS-1:0]   released_q2;

   // Enables and drive decisions
   wire  [`HPR_NUM_PINS-1:0]   pin_raw;
   wire  [`HPR_NUM_PORTS-1:0]  port_en;
   wire                        all_en;
   wire                        drive_p1;
   wire                        drive_p2;
   wire                        drive_gang;
   wire  [`HPR_NUM_PINS-1:0]   released;

   // Next values of the registered outputs
   wire  [`HPR_NUM_PINS-1:0]   pin_fault;
   wire  [`HPR_NUM_PORTS-1:0]  next_oc;
   wire  [`HPR_NUM_PORTS-1:0]  next_powered;
   wire                        next_role;
   hpr_pkg::hpr_roles_t        next_roles;

   // Drive side of the three open-drain pins
   hpr_pkg::hpr_od_drive_t     p1_drive;
   hpr_pkg::hpr_od_drive_t     p2_drive;
   hpr_pkg::hpr_od_drive_t     gang_drive;

   // Gather the raw pins, low bit first
   assign pin_raw = {ganged_power_pin_in, port2_power_ctl_pin_in, port1_power_ctl_pin_in};

   // Attach synchroniser; attach pins idle low, so PHYs start off
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         attach_s1 <= `HPR_ATTACH_RESET;
         attach_s2 <= `HPR_ATTACH_RESET;
      end else begin
         attach_s1 <= attach_in;
         attach_s2 <= attach_s1;
      end
   end

   // Role swap synchroniser
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         swap_s1 <= `HPR_ROLE_DEFAULT;
         swap_s2 <= `HPR_ROLE_DEFAULT;
      end else begin
         swap_s1 <= role_swap_cmd;
         swap_s2 <= swap_s1;
      end
   end

   // Power pin synchroniser; resets to the pull-up level so no fault shows after reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_s1 <= `HPR_PIN_IDLE;
         pin_s2 <= `HPR_PIN_IDLE;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end

   // Release history; a freshly released pin still shows its driven low for two edges
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         released_q1 <= 3'h0;
         released_q2 <= 3'h0;
      end else begin
         released_q1 <= released;
         released_q2 <= released_q1;
      end
   end

   // A port is enabled only when both configuration and host allow it
   assign port_en    = port_cfg_enable & port_host_enable;
   // Ganged pin powers all ports together, so any disabled port drops them all
   assign all_en     = &port_en;
   // Per-port pins are parked low in ganged mode so no stray supply turns on
   assign drive_p1   = ganged_mode | ~port_en[0];
   assign drive_p2   = ganged_mode | ~port_en[1];
   assign drive_gang = ~ganged_mode | ~all_en;
   assign released   = ~{drive_gang, drive_p2, drive_p1};

   // Overcurrent only counts once the released level has crossed the synchroniser;
   // the trade is two extra cycles before the first fault after enabling
   assign pin_fault  = released & released_q1 & released_q2 & ~pin_s2;
   assign next_oc[0] = port_fault(ganged_mode, pin_fault[`HPR_PIN_P1],
                                  pin_fault[`HPR_PIN_GANG]);
   assign next_oc[1] = port_fault(ganged_mode, pin_fault[`HPR_PIN_P2],
                                  pin_fault[`HPR_PIN_GANG]);

   // Next power state, role and role pair
   assign next_powered = ganged_mode ? {2{all_en}} : port_en;
   assign next_role    = swap_s2 ? `HPR_ROLE_SWAPPED : `HPR_ROLE_DEFAULT;
   assign next_roles   = '{port0_upstream: ~swap_s2,
                           port1_upstream: swap_s2};

   // Overcurrent status register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         port_overcurrent <= `HPR_PORTS_RESET;
      end else begin
         port_overcurrent <= next_oc;
      end
   end

   // Role indicator and role pair registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         role_state_ind <= `HPR_ROLE_DEFAULT;
         port_roles     <= `HPR_ROLES_RESET;
      end else begin
         role_state_ind <= next_role;
         port_roles     <= next_roles;
      end
   end

   // PHY gating follows the synchronised attach inputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ss_phy_enable <= `HPR_ATTACH_RESET;
      end else begin
         ss_phy_enable <= attach_s2;
      end
   end

   // Port power status register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         port_powered <= `HPR_PORTS_RESET;
      end else begin
         port_powered <= next_powered;
      end
   end

   // Open-drain drive: release when enabled and in the pin's own mode, pull low otherwise
   assign p1_drive   = od_drive(drive_p1);
   assign p2_drive   = od_drive(drive_p2);
   assign gang_drive = od_drive(drive_gang);

   // Pin outputs; oe is combinational so a disable takes effect at once
   assign port1_power_ctl_pin_out = p1_drive.out;
   assign port1_power_ctl_pin_oe  = p1_drive.oe;
   assign port2_power_ctl_pin_out = p2_drive.out;
   assign port2_power_ctl_pin_oe  = p2_drive.oe;
   assign ganged_power_pin_out    = gang_drive.out;
   assign ganged_power_pin_oe     = gang_drive.oe;
endmodule
`default_nettype wire

// >>> tb/hpr_port_power_role_chk.sv
// Checker on the ports of the port power and role block
`timescale 1ns/1ps
`default_nettype none
module hpr_port_power_role_chk (
   // Clock, reset and control
   input wire logic       clk_sys, rst, ganged_mode, role_swap_cmd, role_state_ind,
   input wire logic [1:0] port_cfg_enable, port_host_enable, port_overcurrent,
   // Pins, roles and attach
   input wire logic       port1_power_ctl_pin_in, port1_power_ctl_pin_oe,
   input wire logic       ganged_power_pin_in, ganged_power_pin_oe,
   input wire logic [3:0] attach_in, ss_phy_enable,
   input wire hpr_pkg::hpr_roles_t port_roles
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Enable is both sources; overcurrent source follows the mode
   wire [1:0] en = port_cfg_enable & port_host_enable;
   wire       oc_pin = ganged_mode ? ganged_power_pin_in : port1_power_ctl_pin_in;
   a_port_drive: assert property (port1_power_ctl_pin_oe == (ganged_mode || !en[0]))
      else $error("port 1 pin drive");
   a_gang_drive: assert property (ganged_power_pin_oe == (!ganged_mode || en != 2'h3))
      else $error("ganged pin drive");
   a_oc_source: assert property ($rose(port_overcurrent[0]) |-> !$past(oc_pin, 3))
      else $error("overcurrent without low pin");
   a_oc_mask: assert property (port_overcurrent[0] |-> $past(en[0]))
      else $error("overcurrent on disabled port");
   a_roles_pair: assert property (port_roles == {!role_state_ind, role_state_ind})
      else $error("roles");
   a_swap_follow: assert property ($stable(role_swap_cmd)[*4] |-> role_state_ind == role_swap_cmd)
      else $error("role indicator");
   a_swap_sync: assert property ($rose(role_state_ind) |-> $past(role_swap_cmd, 3))
      else $error("swap too early");
   a_phy_follow: assert property ($stable(attach_in)[*4] |-> ss_phy_enable == attach_in)
      else $error("phy enable");
endmodule
`default_nettype wire

// >>> tb/hpr_power_switch_model.sv
// Power switch with current monitor on one open-drain pin
`timescale 1ns/1ps
`default_nettype none
module hpr_power_switch_model (
   // Pin drive and fault
   input  wire logic pin_oe,
   input  wire logic fault,
   output logic      pin
);
   // Pull-up wins unless the hub or the monitor pulls low
   assign pin = (pin_oe || fault) ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

// >>> tb/tb_hpr_port_power_role.sv
// Testbench for the port power and role block
`timescale 1ns/1ps
`default_nettype none
module tb_hpr_port_power_role;
   logic       clk_sys = 1'h0, rst = 1'h1, gm = 1'h0, cmd = 1'h0, ind;
   logic [1:0] cfg = 2'h0, host = 2'h0, pwr, oc;
   logic [2:0] oe, pin, fault = 3'h0;
   logic [3:0] att = 4'h0, phy, pat [4] = '{4'h5, 4'ha, 4'h0, 4'hf};
   hpr_pkg::hpr_roles_t roles;
   int num_errors = 0, num_checks = 0;
   hpr_port_power_role u_hpr_port_power_role (.clk_sys, .rst, .ganged_mode(gm),
      .port_cfg_enable(cfg), .port_host_enable(host), .port1_power_ctl_pin_in(pin[0]),
      .port1_power_ctl_pin_out(), .port1_power_ctl_pin_oe(oe[0]), .port2_power_ctl_pin_in(pin[1]),
      .port2_power_ctl_pin_out(), .port2_power_ctl_pin_oe(oe[1]), .ganged_power_pin_in(pin[2]),
      .ganged_power_pin_out(), .ganged_power_pin_oe(oe[2]), .port_powered(pwr),
      .port_overcurrent(oc), .role_swap_cmd(cmd), .role_state_ind(ind), .port_roles(roles),
      .attach_in(att), .ss_phy_enable(phy));
   // Index 0 and 1 are the port switches, index 2 the ganged one
   hpr_power_switch_model u_hpr_power_switch_model [2:0] (.pin_oe(oe), .fault, .pin);
   task automatic chk(string name, logic [3:0] seen, logic [3:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Inputs move 2 ns after the edge so no race with sampling
   task automatic step(int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   task automatic give_verdict;
      if (num_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always #12.5 clk_sys = ~clk_sys;
   // Run takes about 50 cycles; 400 is a hang
   initial begin
      #10000;
      num_errors++;
      give_verdict();
   end
   initial begin
      step(3);
      rst = 1'h0;
      for (int i = 0; i < 16; i++) begin
         {cfg, host} = i[3:0];
         step(1);
         chk("pins and power", {pwr, pin[1:0]}, {2{cfg & host}});
         chk("no false fault", oc, 2'h0);
      end
      gm = 1'h1;
      for (int i = 0; i < 4; i++) begin
         host = i[1:0];
         step(1);
         chk("ganged pins", {oe[1:0], pin[2]}, {2'h3, i == 3});
         chk("ganged power", pwr, {2{i == 3}});
      end
      fault = 3'h4;
      step(4);
      chk("ganged fault", oc, 2'h3);
      {gm, host, fault} = {1'h0, 2'h1, 3'h3};
      step(4);
      chk("port fault", oc, 2'h1);
      for (int i = 1; i >= 0; i--) begin
         cmd = i[0];
         step(2);
         chk("early indicator", ind, !i[0]);
         step(1);
         chk("roles", {ind, roles}, {i[0], !i[0], i[0]});
      end
      foreach (pat[k]) begin
         att = pat[k];
         step(3);
         chk("phy enable", phy, pat[k]);
      end
      give_verdict();
   end
endmodule
bind hpr_port_power_role hpr_port_power_role_chk u_hpr_port_power_role_chk (.*);
`default_nettype wire
